// *** inc/port_pkg.sv ***
// constants and types shared by the cascaded codec serial port
package port_pkg;
   localparam int          WORD_W        = 16;
   localparam int          FIFO_DEPTH    = 8;
   // control word layout
   localparam int          CTRL_BIT      = 15;
   localparam int          ADDR_HI       = 13;
   localparam int          ADDR_LO       = 11;
   localparam int          SEL_HI        = 10;
   localparam int          SEL_LO        = 8;
   localparam logic [2:0]  REG_MODE      = 3'h0;
   localparam logic [2:0]  REG_CLOCK     = 3'h1;
   localparam logic [2:0]  REG_POWER     = 3'h2;
   // mode register fields
   localparam int          PDS_BIT       = 3;
   // clock register fields
   localparam int          DIV_LO        = 0;
   localparam int          SCLK_LO       = 2;
   localparam int          SAMP_LO       = 4;
   // timing counts: prescale in system clock cycles, sample base in divided clock ticks, word length in bits
   localparam logic [3:0]  MCLK_PRESCALE = 4'h4;
   localparam logic [11:0] SAMP_BASE     = 12'h100;
   localparam logic [4:0]  WORD_BITS     = 5'h10;
   // values after reset
   localparam logic [1:0]  RST_DIV       = 2'h0;
   localparam logic [1:0]  RST_SCLK      = 2'h0;
   localparam logic [1:0]  RST_SAMP      = 2'h0;
   localparam logic [2:0]  RST_DEVCNT    = 3'h1;
   localparam logic [7:0]  RST_POWER     = 8'h00;
   // output shifter states
   typedef enum logic [2:0] {
      TX_IDLE  = 3'b001,
      TX_FS    = 3'b010,
      TX_SHIFT = 3'b100
   } tx_state_type;
endpackage : port_pkg

// *** hw/sample_fifo.sv ***
// parameterised first-in first-out buffer for adc samples
`timescale 1ns/1ps
module sample_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_in,
   input  wire logic             rstn_in,
   input  wire logic             in_valid_in,
   output logic                  in_ready_out,
   input  wire logic [WIDTH-1:0] in_data_in,
   output logic                  out_valid_out,
   input  wire logic             out_ready_in,
   output logic      [WIDTH-1:0] out_data_out
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wr;
      logic [AW-1:0]               rd;
      logic [AW:0]                 cnt;
      logic                        ready;
   } fifo_type;
   fifo_type st_ff, nxt_st;
   logic     push, pop;

   // push when room, pop when data; ready registered from next count
   always_comb
   begin
      nxt_st = st_ff;
      push   = in_valid_in && st_ff.ready;
      pop    = out_ready_in && (st_ff.cnt != '0);
      if (push)
      begin
         nxt_st.mem[st_ff.wr] = in_data_in;
         nxt_st.wr            = (st_ff.wr == AW'(DEPTH - 1)) ? '0 : st_ff.wr + 1'b1;
      end
      if (pop)
         nxt_st.rd = (st_ff.rd == AW'(DEPTH - 1)) ? '0 : st_ff.rd + 1'b1;
      nxt_st.cnt   = st_ff.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      nxt_st.ready = nxt_st.cnt != (AW+1)'(DEPTH);
   end

   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
         st_ff <= '{mem: '0, wr: '0, rd: '0, cnt: '0, ready: 1'b1};
      else
         st_ff <= nxt_st;
   end

   assign in_ready_out  = st_ff.ready;
   assign out_valid_out = st_ff.cnt != '0;
   assign out_data_out  = st_ff.mem[st_ff.rd];
endmodule : sample_fifo

// *** hw/cascaded_codec_serial_port.sv ***
// serial port of a cascadable voice codec: routing, setup and dac addressing
`timescale 1ns/1ps
// Operation
// R1: each sampling event raises output frame sync and sends the serial register.
// R2: in loopback the host starts its next word on the last output frame sync.
// R3: a word that is no control word for us is forwarded unchanged.
// R4: control word with nonzero address is decremented and forwarded.
// R5: control word with address zero writes the selected register, no forward.
// R6: clock register sets divider, serial clock rate and sample rate.
// R7: host sends all cascade control words back to back.
// R8: host sends farthest device word first; replies return reversed.
// R9: host should target one register per sampling event group.
// R10: host programs clock, then power, then mode register.
// R11: power register writes power up the analog sections.
// R12: mode register loads device count; select bit enters data mode.
// R13: data mode takes all words as dac samples; adc loaded at sampling.
// R14: when frame count equals device count, the dac register loads.
// R15: below device count, forward the current serial register contents.
// R16: every input frame sync increments the frame counter (the code counts only in data mode).
// R17: frame counter clears right after a dac update.
// R18: host repeats adc read and dac write on every sampling event.
// R19: address field is three bits and wraps from zero to seven.
// R20: in program mode a set top bit marks a control word.
module cascaded_codec_serial_port (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        sdi_in,
   input  wire logic        serial_in_frame_sync_in,
   output logic             sclk_out,
   output logic             sdo_out,
   output logic             serial_out_frame_sync_out,
   input  wire logic [15:0] adc_data_in,
   input  wire logic        adc_valid_in,
   output logic             adc_ready_out,
   output logic [15:0]      dac_data_out,
   output logic             dac_update_out,
   output logic             data_mode_out,
   output logic [7:0]       power_ctrl_out
);
   typedef struct packed {
      logic [2:0]                 sdi_s;
      logic [2:0]                 ifs_s;
      logic                       sdi_flt;
      logic                       ifs_flt;
      logic [3:0]                 mclk_cnt;
      logic [1:0]                 dm_cnt;
      logic [2:0]                 sclk_cnt;
      logic                       sclk;
      logic [11:0]                samp_cnt;
      logic                       rx_act;
      logic [3:0]                 rx_cnt;
      logic [15:0]                rx_sh;
      port_pkg::tx_state_type     tx_state;
      logic [4:0]                 tx_cnt;
      logic [15:0]                tx_sh;
      logic                       ofs;
      logic                       sdo;
      logic                       pend;
      logic [15:0]                pend_word;
      logic [15:0]                ser;
      logic                       data_mode;
      logic [2:0]                 dev_count;
      logic [3:0]                 frame_cnt;
      logic [1:0]                 div_code;
      logic [1:0]                 sclk_code;
      logic [1:0]                 samp_code;
      logic [7:0]                 power;
      logic [15:0]                dac;
      logic                       dac_upd;
   } state_type;

   state_type   st_ff, nxt_st;
   logic        mclk_tick, dm_tick, half_hit, sclk_rise, sclk_fall, samp_evt;
   logic        done, is_ctrl, self_write, fwd_req, count_hit, pop;
   logic [15:0] rx_word;
   logic [2:0]  rx_addr;
   logic [3:0]  count_lim;
   logic        fifo_valid;
   logic [15:0] fifo_data;

   // address field decrement with three-bit wrap
   function automatic logic [2:0] addr_dec(input logic [2:0] a);
      addr_dec = a - 3'h1;
   endfunction : addr_dec

   // replace the address field of a control word
   function automatic logic [15:0] set_addr(input logic [15:0] w, input logic [2:0] a);
      set_addr                                   = w;
      set_addr[port_pkg::ADDR_HI:port_pkg::ADDR_LO] = a;
   endfunction : set_addr

   // adc samples wait here until a sampling event takes them
   sample_fifo #(
      .WIDTH (port_pkg::WORD_W),
      .DEPTH (port_pkg::FIFO_DEPTH)
   ) adc_fifo (
      .clk_in        (clk_in),
      .rstn_in       (rstn_in),
      .in_valid_in   (adc_valid_in),
      .in_ready_out  (adc_ready_out),
      .in_data_in    (adc_data_in),
      .out_valid_out (fifo_valid),
      .out_ready_in  (pop),
      .out_data_out  (fifo_data)
   );

   // timing ticks, received word decode and routing decisions
   always_comb
   begin
      mclk_tick  = st_ff.mclk_cnt == port_pkg::MCLK_PRESCALE - 4'h1;
      // R6 divider ratio
      dm_tick    = mclk_tick && (st_ff.dm_cnt == st_ff.div_code);
      // R6 serial clock rate
      half_hit   = st_ff.sclk_cnt == 3'((4'h1 << st_ff.sclk_code) - 4'h1);
      sclk_rise  = dm_tick && half_hit && !st_ff.sclk;
      sclk_fall  = dm_tick && half_hit && st_ff.sclk;
      // R6 sample rate
      samp_evt   = dm_tick && (st_ff.samp_cnt ==
                   (port_pkg::SAMP_BASE << st_ff.samp_code) - 12'h1);
      done       = sclk_fall && st_ff.rx_act && (st_ff.rx_cnt == 4'hf);
      rx_word    = {st_ff.rx_sh[14:0], st_ff.sdi_flt};
      rx_addr    = rx_word[port_pkg::ADDR_HI:port_pkg::ADDR_LO];
      // R20 top bit marks a control word
      is_ctrl    = !st_ff.data_mode && rx_word[port_pkg::CTRL_BIT];
      // R5 address zero is ours
      self_write = done && is_ctrl && (rx_addr == 3'h0);
      count_lim  = {st_ff.dev_count == 3'h0, st_ff.dev_count};
      // R14 compare frame count with device count
      count_hit  = done && st_ff.data_mode && (st_ff.frame_cnt + 4'h1 == count_lim);
      fwd_req    = done && !self_write && !count_hit;
      pop        = samp_evt && fifo_valid;
   end

   // next state of the whole port
   always_comb
   begin
      nxt_st         = st_ff;
      nxt_st.dac_upd = 1'b0;
      // input pins pass three flip-flops; a change counts when the last two agree
      nxt_st.sdi_s   = {st_ff.sdi_s[1:0], sdi_in};
      nxt_st.ifs_s   = {st_ff.ifs_s[1:0], serial_in_frame_sync_in};
      if (st_ff.sdi_s[1] == st_ff.sdi_s[2])
         nxt_st.sdi_flt = st_ff.sdi_s[2];
      if (st_ff.ifs_s[1] == st_ff.ifs_s[2])
         nxt_st.ifs_flt = st_ff.ifs_s[2];
      // clock dividers
      nxt_st.mclk_cnt = mclk_tick ? 4'h0 : st_ff.mclk_cnt + 4'h1;
      if (mclk_tick)
         nxt_st.dm_cnt = dm_tick ? 2'h0 : st_ff.dm_cnt + 2'h1;
      if (dm_tick)
      begin
         nxt_st.sclk_cnt = half_hit ? 3'h0 : st_ff.sclk_cnt + 3'h1;
         nxt_st.samp_cnt = samp_evt ? 12'h0 : st_ff.samp_cnt + 12'h1;
         if (half_hit)
            nxt_st.sclk = !st_ff.sclk;
      end
      // receiver samples on the falling serial clock
      if (sclk_fall)
      begin
         if (!st_ff.rx_act && st_ff.ifs_flt)
         begin
            nxt_st.rx_act = 1'b1;
            nxt_st.rx_cnt = 4'h0;
         end
         else if (st_ff.rx_act)
         begin
            nxt_st.rx_sh  = rx_word;
            nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
            if (st_ff.rx_cnt == 4'hf)
               nxt_st.rx_act = 1'b0;
         end
      end
      // R1 sampling event loads the serial register and requests a frame
      if (samp_evt)
      begin
         // R13 serial register takes the adc result
         nxt_st.ser       = pop ? fifo_data : 16'h0000;
         nxt_st.pend      = 1'b1;
         nxt_st.pend_word = nxt_st.ser;
      end
      // R5 register write by a control word addressed to us
      if (self_write)
      begin
         case (rx_word[port_pkg::SEL_HI:port_pkg::SEL_LO])
            // R12 device count and program/data select
            port_pkg::REG_MODE:
            begin
               nxt_st.dev_count = rx_word[2:0];
               nxt_st.data_mode = rx_word[port_pkg::PDS_BIT];
            end
            // R6 clock configuration
            port_pkg::REG_CLOCK:
            begin
               nxt_st.div_code  = rx_word[port_pkg::DIV_LO +: 2];
               nxt_st.sclk_code = rx_word[port_pkg::SCLK_LO +: 2];
               nxt_st.samp_code = rx_word[port_pkg::SAMP_LO +: 2];
            end
            // R11 analog power bits
            port_pkg::REG_POWER:
               nxt_st.power = rx_word[7:0];
            default:
               nxt_st.power = st_ff.power;
         endcase
      end
      // forwarding downstream
      if (fwd_req)
      begin
         nxt_st.pend = 1'b1;
         if (st_ff.data_mode)
         begin
            // R15 received word fills the serial register and moves on
            nxt_st.pend_word = rx_word;
            nxt_st.ser       = rx_word;
         end
         else if (is_ctrl)
            // R4 R19 decrement address with wrap
            nxt_st.pend_word = set_addr(rx_word, addr_dec(rx_addr));
         else
            // R3 forward unchanged
            nxt_st.pend_word = rx_word;
      end
      // R16 every input frame counts in data mode
      if (done && st_ff.data_mode)
         nxt_st.frame_cnt = st_ff.frame_cnt + 4'h1;
      // R14 R17 dac load and counter clear
      if (count_hit)
      begin
         nxt_st.dac       = rx_word;
         nxt_st.dac_upd   = 1'b1;
         nxt_st.frame_cnt = 4'h0;
      end
      // output shifter launches on the rising serial clock
      if (sclk_rise)
      begin
         case (st_ff.tx_state)
            port_pkg::TX_IDLE:
               if (st_ff.pend && !fwd_req && !samp_evt)
               begin
                  nxt_st.pend     = 1'b0;
                  nxt_st.ofs      = 1'b1;
                  nxt_st.tx_sh    = st_ff.pend_word;
                  nxt_st.tx_state = port_pkg::TX_FS;
               end
            port_pkg::TX_FS:
            begin
               nxt_st.ofs      = 1'b0;
               nxt_st.sdo      = st_ff.tx_sh[15];
               nxt_st.tx_sh    = {st_ff.tx_sh[14:0], 1'b0};
               nxt_st.tx_cnt   = 5'h1;
               nxt_st.tx_state = port_pkg::TX_SHIFT;
            end
            port_pkg::TX_SHIFT:
               if (st_ff.tx_cnt == port_pkg::WORD_BITS)
               begin
                  nxt_st.sdo      = 1'b0;
                  nxt_st.tx_state = port_pkg::TX_IDLE;
               end
               else
               begin
                  nxt_st.sdo    = st_ff.tx_sh[15];
                  nxt_st.tx_sh  = {st_ff.tx_sh[14:0], 1'b0};
                  nxt_st.tx_cnt = st_ff.tx_cnt + 5'h1;
               end
            default:
               nxt_st.tx_state = port_pkg::TX_IDLE;
         endcase
      end
   end

   // state register
   always_ff @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         st_ff           <= '0;
         st_ff.tx_state  <= port_pkg::TX_IDLE;
         st_ff.div_code  <= port_pkg::RST_DIV;
         st_ff.sclk_code <= port_pkg::RST_SCLK;
         st_ff.samp_code <= port_pkg::RST_SAMP;
         st_ff.dev_count <= port_pkg::RST_DEVCNT;
         st_ff.power     <= port_pkg::RST_POWER;
      end
      else
         st_ff <= nxt_st;
   end

   // outputs straight from the state register
   assign sclk_out                  = st_ff.sclk;
   assign sdo_out                   = st_ff.sdo;
   assign serial_out_frame_sync_out = st_ff.ofs;
   assign dac_data_out              = st_ff.dac;
   assign dac_update_out            = st_ff.dac_upd;
   assign data_mode_out             = st_ff.data_mode;
   assign power_ctrl_out            = st_ff.power;

   // checks
   a_fs_then_shift: assert property (@(posedge clk_in) disable iff (!rstn_in) // R1
      $fell(st_ff.ofs) |-> st_ff.tx_state == port_pkg::TX_SHIFT)
      else $error("frame sync not followed by data");
   a_self_no_fwd: assert property (@(posedge clk_in) disable iff (!rstn_in) // R5
      (self_write && !samp_evt) |=> st_ff.pend == $past(st_ff.pend)
                                   && st_ff.pend_word == $past(st_ff.pend_word))
      else $error("own control word forwarded");
   a_ctrl_addr_dec: assert property (@(posedge clk_in) disable iff (!rstn_in) // R4
      (fwd_req && is_ctrl) |=> st_ff.pend_word[13:11] == $past(rx_addr) - 3'h1
                               && st_ff.pend)
      else $error("control address not decremented");
   a_plain_forward: assert property (@(posedge clk_in) disable iff (!rstn_in) // R3
      (fwd_req && !is_ctrl && !st_ff.data_mode) |=> st_ff.pend_word == $past(rx_word))
      else $error("word not forwarded unchanged");
   a_dac_on_count: assert property (@(posedge clk_in) disable iff (!rstn_in) // R14
      count_hit |=> dac_update_out && dac_data_out == $past(rx_word))
      else $error("dac not loaded at device count");
   a_count_clear: assert property (@(posedge clk_in) disable iff (!rstn_in) // R17
      dac_update_out |-> st_ff.frame_cnt == 4'h0)
      else $error("frame counter not cleared");
   a_count_step: assert property (@(posedge clk_in) disable iff (!rstn_in) // R16
      (done && st_ff.data_mode && !count_hit) |=> st_ff.frame_cnt == $past(st_ff.frame_cnt) + 4'h1)
      else $error("frame counter missed a pulse");
   a_pass_serial: assert property (@(posedge clk_in) disable iff (!rstn_in) // R15
      (fwd_req && st_ff.data_mode) |=> st_ff.pend_word == $past(rx_word)
                                       && st_ff.ser == $past(rx_word))
      else $error("serial contents not passed on");
   a_mode_entry: assert property (@(posedge clk_in) disable iff (!rstn_in) // R12
      (self_write && rx_word[10:8] == port_pkg::REG_MODE)
      |=> data_mode_out == $past(rx_word[port_pkg::PDS_BIT]))
      else $error("mode register write ignored");
   a_sample_load: assert property (@(posedge clk_in) disable iff (!rstn_in) // R13
      (samp_evt && pop && !fwd_req) |=> st_ff.ser == $past(fifo_data) && st_ff.pend)
      else $error("adc result not loaded at sampling");
   a_idle_line_low: assert property (@(posedge clk_in) disable iff (!rstn_in) // R1
      (st_ff.tx_state == port_pkg::TX_IDLE) |-> !sdo_out)
      else $error("data line not low while idle");
   a_clock_write: assert property (@(posedge clk_in) disable iff (!rstn_in) // R6
      (self_write && rx_word[10:8] == port_pkg::REG_CLOCK)
      |=> st_ff.sclk_code == $past(rx_word[port_pkg::SCLK_LO +: 2]))
      else $error("clock register write ignored");
   a_power_write: assert property (@(posedge clk_in) disable iff (!rstn_in) // R11
      (self_write && rx_word[10:8] == port_pkg::REG_POWER)
      |=> power_ctrl_out == $past(rx_word[7:0]))
      else $error("power register write ignored");
   c_fifo_full: cover property (@(posedge clk_in) disable iff (!rstn_in) !adc_ready_out);
   c_dac_update: cover property (@(posedge clk_in) disable iff (!rstn_in) dac_update_out);
   c_ctrl_fwd: cover property (@(posedge clk_in) disable iff (!rstn_in) fwd_req && is_ctrl);
   c_data_mode: cover property (@(posedge clk_in) disable iff (!rstn_in) $rose(data_mode_out));
endmodule : cascaded_codec_serial_port

// *** testbench/dsp_port_model.sv ***
// host serial port model: loopback bursts of queued words and capture of returned words
`timescale 1ns/1ps
module dsp_port_model (
   input  wire logic        clk_in,
   input  wire logic        rstn_in,
   input  wire logic        sclk_in,
   input  wire logic        sdo_in,
   input  wire logic        ofs_in,
   output logic             sdi_out,
   output logic             fs_out,
   output logic [15:0]      rx_word_out,
   output logic             rx_valid_out
);
   logic [15:0] tx_q[$];
   logic [15:0] cur_ff;
   logic [15:0] rx_sh_ff;
   logic [4:0]  tx_bit_ff;
   logic [4:0]  rx_bit_ff;
   logic        go_ff;
   logic        sclk_q_ff;

   // queue a word for the next burst
   task push_word(input logic [15:0] w);
      tx_q.push_back(w);
   endtask : push_word

   // all lines change one clock after a serial clock fall, far from the next sample
   always @(posedge clk_in or negedge rstn_in)
   begin
      if (!rstn_in)
      begin
         {cur_ff, rx_sh_ff, rx_word_out} <= '0;
         {tx_bit_ff, rx_bit_ff, go_ff, sclk_q_ff} <= '0;
         {sdi_out, fs_out, rx_valid_out} <= '0;
      end
      else
      begin
         sclk_q_ff <= sclk_in;
         rx_valid_out <= 1'b0;
         if (sclk_q_ff && !sclk_in)
         begin
            if (tx_bit_ff != 5'h00)
            begin
               fs_out <= 1'b0;
               sdi_out <= cur_ff[tx_bit_ff-1];
               tx_bit_ff <= tx_bit_ff - 5'h01;
            end
            // queued words leave back to back, farthest device first
            else if (go_ff && tx_q.size() > 0)
            begin
               cur_ff <= tx_q.pop_front();
               fs_out <= 1'b1;
               tx_bit_ff <= 5'h10;
            end
            else
            begin
               fs_out <= 1'b0;
               sdi_out <= ~sdi_out;
               go_ff <= 1'b0;
            end
            // a returned frame sync also starts the host transmit burst
            if (rx_bit_ff == 5'h00 && ofs_in)
            begin
               rx_bit_ff <= 5'h10;
               go_ff <= 1'b1;
            end
            else if (rx_bit_ff != 5'h00)
            begin
               rx_sh_ff <= {rx_sh_ff[14:0], sdo_in};
               rx_bit_ff <= rx_bit_ff - 5'h01;
               rx_word_out <= {rx_sh_ff[14:0], sdo_in};
               rx_valid_out <= (rx_bit_ff == 5'h01);
            end
         end
      end
   end
endmodule : dsp_port_model

// *** testbench/cascaded_codec_serial_port_tb_top.sv ***
// testbench: word routing, setup writes, adc buffering and dac addressing
`timescale 1ns/1ps
module cascaded_codec_serial_port_tb_top;
   logic        clk, rstn, sdi, ifs, sclk, sdo, ofs, adc_valid, adc_ready;
   logic        dac_upd, dmode, rx_valid;
   logic [15:0] adc_data, dac_data, rx_word, w0, w1;
   logic [7:0]  power;
   logic [15:0] exp_rx[$];
   logic [15:0] exp_dac[$];
   int          fail_count, check_count, rx_total, dac_total, n, p;

   cascaded_codec_serial_port dut (.clk_in(clk), .rstn_in(rstn), .sdi_in(sdi),
      .serial_in_frame_sync_in(ifs), .sclk_out(sclk), .sdo_out(sdo),
      .serial_out_frame_sync_out(ofs), .adc_data_in(adc_data), .adc_valid_in(adc_valid),
      .adc_ready_out(adc_ready), .dac_data_out(dac_data), .dac_update_out(dac_upd),
      .data_mode_out(dmode), .power_ctrl_out(power));
   dsp_port_model dsp (.clk_in(clk), .rstn_in(rstn), .sclk_in(sclk), .sdo_in(sdo),
      .ofs_in(ofs), .sdi_out(sdi), .fs_out(ifs), .rx_word_out(rx_word),
      .rx_valid_out(rx_valid));

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [15:0] ctrl(input logic [2:0] a, input logic [2:0] s,
                                        input logic [7:0] d);
      return {1'b1, 1'b0, a, s, d};
   endfunction : ctrl

   task results;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : results

   task cmp_word(input string nm, input logic [15:0] e, input logic [15:0] g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : cmp_word

   task cmp_flag(input string nm, input logic e, input logic g);
      check_count++;
      if (g !== e)
      begin
         fail_count++;
         $display("mismatch %s expected %b seen %b", nm, e, g);
      end
   endtask : cmp_flag

   task automatic wait_cnt(input string nm, ref int c, input int t);
      int k;
      for (k = 0; k < 20000 && c < t; k++) @(posedge clk);
      if (c < t)
      begin
         fail_count++;
         $display("mismatch %s count expected %0d seen %0d", nm, t, c);
         results();
      end
   endtask : wait_cnt

   // two words to the cascade; the returned word ea is noted
   task pair(input logic [15:0] a, input logic [15:0] b, input logic [15:0] ea);
      exp_rx.push_back(ea);
      dsp.push_word(a);
      dsp.push_word(b);
      n++;
      wait_cnt("serial word", rx_total, n);
   endtask : pair

   // serial clock period in system clocks, sampled mid cycle
   task sclk_period(output int q);
      int k;
      for (k = 0; k < 64 && sclk !== 1'b0; k++) @(negedge clk);
      for (k = 0; k < 64 && sclk !== 1'b1; k++) @(negedge clk);
      for (q = 0; q < 64 && sclk !== 1'b0; q++) @(negedge clk);
      for (k = 0; k < 64 && sclk !== 1'b1; k++) @(negedge clk);
      q = q + k;
   endtask : sclk_period

   // oldest note against each nonzero returned word and each dac load
   always @(posedge clk)
   begin
      if (rx_valid === 1'b1 && rx_word !== 16'h0000)
      begin
         rx_total++;
         cmp_word("serial word", exp_rx.size() ? exp_rx.pop_front() : 16'h0, rx_word);
      end
      if (dac_upd === 1'b1)
      begin
         dac_total++;
         cmp_word("dac word", exp_dac.size() ? exp_dac.pop_front() : 16'h0, dac_data);
      end
   end

   initial
   begin
      {rstn, adc_valid, adc_data, fail_count, check_count, rx_total, dac_total, n} = '0;
      void'($urandom(55733));
      repeat (4) @(posedge clk);
      rstn <= 1'b1;
      @(negedge clk);
      cmp_flag("data mode", 1'b0, dmode);
      cmp_word("power", 16'h0000, {8'h00, power});
      cmp_word("dac", 16'h0000, dac_data);
      cmp_flag("adc ready", 1'b1, adc_ready);
      // plain word passes unchanged, addressed word leaves decremented
      w0 = {1'b0, 15'($urandom())} | 16'h0001;
      w1 = ctrl(3'h3, port_pkg::REG_POWER, 8'($urandom()));
      exp_rx.push_back(w0);
      n++;
      pair(w0, w1, w1 - 16'h0800);
      w0 = ctrl(3'h1, port_pkg::REG_CLOCK, 8'h04);
      pair(w0, ctrl(3'h0, port_pkg::REG_CLOCK, 8'h04), w0 - 16'h0800);
      sclk_period(p);
      cmp_word("sclk period", 16'h0010, 16'(p));
      w1 = 16'($urandom());
      w0 = ctrl(3'h1, port_pkg::REG_POWER, w1[15:8]);
      pair(w0, ctrl(3'h0, port_pkg::REG_POWER, w1[7:0]), w0 - 16'h0800);
      cmp_word("power", {8'h00, w1[7:0]}, {8'h00, power});
      // fill the buffer until it refuses, drain it at sampling events
      for (int i = 0; i < 8; i++)
      begin
         w0 = 16'($urandom()) | 16'h0001;
         adc_data <= w0;
         adc_valid <= 1'b1;
         exp_rx.push_back(w0);
         @(posedge clk);
      end
      adc_valid <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      cmp_flag("adc ready", 1'b0, adc_ready);
      n += 8;
      wait_cnt("serial word", rx_total, n);
      // mode last, two devices, data mode
      w0 = ctrl(3'h1, port_pkg::REG_MODE, 8'h0a);
      pair(w0, ctrl(3'h0, port_pkg::REG_MODE, 8'h0a), w0 - 16'h0800);
      @(negedge clk);
      cmp_flag("data mode", 1'b1, dmode);
      // every word counts; the first of each pair is passed on, the second loads the dac
      for (int i = 0; i < 3; i++)
      begin
         w0 = 16'($urandom()) | 16'h0001;
         w1 = 16'($urandom());
         exp_rx.push_back(w0);
         exp_dac.push_back(w1);
         dsp.push_word(w0);
         dsp.push_word(w1);
         n++;
         wait_cnt("dac update", dac_total, i + 1);
         wait_cnt("serial word", rx_total, n);
      end
      results();
   end
endmodule : cascaded_codec_serial_port_tb_top
